// ### rtl/omarb_regs.vh
// Constants for the operation mode arbiter: offsets, fields, resets, codes
// Summary of operation
// - PU/External swap only when motor stopped, except at setting 6
// - PU/External input active at settings 0,6,7
// - Setting 0: switch on gives External, else PU
// - Setting 1 pins the mode to PU
// - Setting 2 ignores PU/External, allows NET
// - Settings 3,4 pin combined mode
// - Setting 7 interlock off forces External
// - Fixed priority order among settings and inputs
// - NET inputs act at settings 0,2,6,7 only
// - NET/PU switch on gives PU, off NET
// - NET/External on overrides to NET
// - NET/PU off still PU if PU/External off
// - NET becomes PU without option at source 0; at startup 10 with setting 2 NET is kept
// - Startup 10 with setting 2 pins NET
// - Startup 10: NET/PU never yields External
// - Startup 10, setting 7: External/PU swapping
// - NET/External on gives NET, off External at setting 2
// - NET/External off at settings 0,6,7: PU/External or NET/PU decides
// - Setting 2 with NET/External gives PU only when NET falls back at source 0
`ifndef OMARB_REGS_VH
`define OMARB_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OMARB_CTRL_OFS      4'h0
`define OMARB_ASSIGN_OFS    4'h4
`define OMARB_STATUS_OFS    4'h8

// ****************************************************************
// Control register fields and reset values
// ****************************************************************
`define OMARB_MSEL_LSB      0
`define OMARB_SMODE_LSB     8
`define OMARB_NCS_BIT       16
`define OMARB_MSEL_RST      4'h0
`define OMARB_SMODE_RST     4'h0
`define OMARB_NCS_RST       1'b0

// Assignment register: which terminal functions are present
`define OMARB_ASG_PUEXT_BIT  0
`define OMARB_ASG_NETPU_BIT  1
`define OMARB_ASG_NETEXT_BIT 2
`define OMARB_ASG_RST        3'h0

// ****************************************************************
// Setting codes
// ****************************************************************
`define OMARB_MS_0          4'h0
`define OMARB_MS_1          4'h1
`define OMARB_MS_2          4'h2
`define OMARB_MS_3          4'h3
`define OMARB_MS_4          4'h4
`define OMARB_MS_6          4'h6
`define OMARB_MS_7          4'h7
`define OMARB_SM_0          4'h0
`define OMARB_SM_1          4'h1
`define OMARB_SM_10         4'ha

// ****************************************************************
// Operation mode codes and bus answers
// ****************************************************************
`define OMARB_MODE_EXT      2'h0
`define OMARB_MODE_PU       2'h1
`define OMARB_MODE_NET      2'h2
`define OMARB_MODE_COMB     2'h3
`define OMARB_RESP_OKAY     2'h0
`define OMARB_RESP_DECERR   2'h3

`endif

// ### rtl/omarb_top.v
// Operation mode arbiter with AXI4-Lite register access
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "omarb_regs.vh"

module omarb_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pu_ext_switch,
  input  wire        net_pu_switch,
  input  wire        net_ext_switch,
  input  wire        pu_interlock,
  input  wire        motor_running,
  input  wire        start_cmd,
  input  wire        comm_option_fitted,
  output reg  [1:0]  op_mode_q,
  output reg         output_stop_q,
  output reg         mode_pending_q
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  reg  [6:0]  pin_meta_q;
  reg  [6:0]  pin_sync_q;
  wire [6:0]  pin_raw;

  // Pins may change at any moment; two stages keep metastability out
  assign pin_raw = {comm_option_fitted,
                    start_cmd,
                    motor_running,
                    pu_interlock,
                    net_ext_switch,
                    net_pu_switch,
                    pu_ext_switch};

  always @(posedge clk) begin
    if (!rst_b) begin
      pin_meta_q <= 7'h00;
      pin_sync_q <= 7'h00;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Only the second stage is read; the first may still be settling
  wire        s_pu_ext;
  wire        s_net_pu;
  wire        s_net_ext;
  wire        s_ilock;
  wire        s_running;
  wire        s_start;
  wire        s_option;

  assign s_pu_ext  = pin_sync_q[0];
  assign s_net_pu  = pin_sync_q[1];
  assign s_net_ext = pin_sync_q[2];
  assign s_ilock   = pin_sync_q[3];
  assign s_running = pin_sync_q[4];
  assign s_start   = pin_sync_q[5];
  assign s_option  = pin_sync_q[6];

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  reg  [3:0]  mode_select_q;
  reg  [3:0]  startup_mode_q;
  reg         net_command_source_q;
  reg  [2:0]  assign_q;
  reg         aw_full_q;
  reg         w_full_q;
  reg  [3:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;

  wire        aw_take;
  wire        w_take;
  wire        wr_fire;
  wire        aw_d;
  wire        w_d;
  wire        bvalid_d;
  wire        wr_ctrl;
  wire        wr_asg;
  wire        wr_hit;

  wire        ar_take;
  wire        rvalid_d;

  wire [31:0] ctrl_word;
  wire [31:0] asg_word;
  wire [31:0] status_word;

  assign aw_take  = s_axi_awvalid & s_axi_awready;
  assign w_take   = s_axi_wvalid & s_axi_wready;
  assign wr_fire  = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign aw_d     = (aw_full_q & ~wr_fire) | aw_take;
  assign w_d      = (w_full_q & ~wr_fire) | w_take;
  // Answer stands until the master takes it; no new write meanwhile
  assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);
  assign wr_ctrl  = wr_fire & (awaddr_q == `OMARB_CTRL_OFS);
  assign wr_asg   = wr_fire & (awaddr_q == `OMARB_ASSIGN_OFS);
  assign wr_hit   = wr_ctrl | wr_asg | (awaddr_q == `OMARB_STATUS_OFS);
  assign ar_take  = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // Read words are assembled field by field; unused bits read as zero
  assign ctrl_word   = {15'h0000,
                        net_command_source_q,
                        4'h0,
                        startup_mode_q,
                        4'h0,
                        mode_select_q};
  assign asg_word    = {29'h00000000,
                        assign_q};
  assign status_word = {16'h0000,
                        1'b0,
                        pin_sync_q,
                        4'h0,
                        mode_pending_q,
                        output_stop_q,
                        op_mode_q};

  // ****************************************************************
  // Register bus write channel
  // ****************************************************************
  // Address and data may arrive in either order; each waits in its holder
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_awready        <= 1'b0;
      s_axi_wready         <= 1'b0;
      s_axi_bvalid         <= 1'b0;
      s_axi_bresp          <= `OMARB_RESP_OKAY;
      aw_full_q            <= 1'b0;
      w_full_q             <= 1'b0;
      awaddr_q             <= 4'h0;
      wdata_q              <= 32'h00000000;
      wstrb_q              <= 4'h0;
    end else begin
      aw_full_q     <= aw_d;
      w_full_q      <= w_d;
      s_axi_awready <= ~aw_d & ~bvalid_d;
      s_axi_wready  <= ~w_d & ~bvalid_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `OMARB_RESP_OKAY : `OMARB_RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Setting registers
  // ****************************************************************
  // Status is read-only; writes there are accepted and dropped
  always @(posedge clk) begin
    if (!rst_b) begin
      mode_select_q        <= `OMARB_MSEL_RST;
      startup_mode_q       <= `OMARB_SMODE_RST;
      net_command_source_q <= `OMARB_NCS_RST;
      assign_q             <= `OMARB_ASG_RST;
    end else begin
      // Byte lanes let software change one setting without a read first
      if (wr_ctrl && wstrb_q[0]) begin
        mode_select_q <= wdata_q[`OMARB_MSEL_LSB +: 4];
      end
      if (wr_ctrl && wstrb_q[1]) begin
        startup_mode_q <= wdata_q[`OMARB_SMODE_LSB +: 4];
      end
      if (wr_ctrl && wstrb_q[2]) begin
        net_command_source_q <= wdata_q[`OMARB_NCS_BIT];
      end
      if (wr_asg && wstrb_q[0]) begin
        assign_q <= wdata_q[2:0];
      end
    end
  end

  // ****************************************************************
  // Register bus read channel
  // ****************************************************************
  // Read data is captured when the address is taken, held until rready
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `OMARB_RESP_OKAY;
    end else begin
      s_axi_rvalid  <= rvalid_d;
      s_axi_arready <= ~rvalid_d;
      if (ar_take) begin
        s_axi_rresp <= `OMARB_RESP_OKAY;
        if (s_axi_araddr == `OMARB_CTRL_OFS) begin
          s_axi_rdata <= ctrl_word;
        end else if (s_axi_araddr == `OMARB_ASSIGN_OFS) begin
          s_axi_rdata <= asg_word;
        end else if (s_axi_araddr == `OMARB_STATUS_OFS) begin
          s_axi_rdata <= status_word;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `OMARB_RESP_DECERR;
        end
      end
    end
  end

  // ****************************************************************
  // Mode target decision
  // ****************************************************************
  wire        asg_pu_ext;
  wire        asg_net_pu;
  wire        asg_net_ext;

  wire        ms_is_0;
  wire        ms_is_2;
  wire        ms_is_6;
  wire        ms_is_7;
  wire        sm_is_10;
  wire        sm_is_0_1;
  wire [1:0]  net_mode;
  wire        pu_ext_on;
  wire        pu_ext_off;

  // ****************************************************************
  // Setting decode
  // ****************************************************************
  assign asg_pu_ext  = assign_q[`OMARB_ASG_PUEXT_BIT];
  assign asg_net_pu  = assign_q[`OMARB_ASG_NETPU_BIT];
  assign asg_net_ext = assign_q[`OMARB_ASG_NETEXT_BIT];
  assign ms_is_0     = (mode_select_q == `OMARB_MS_0);
  assign ms_is_2     = (mode_select_q == `OMARB_MS_2);
  assign ms_is_6     = (mode_select_q == `OMARB_MS_6);
  assign ms_is_7     = (mode_select_q == `OMARB_MS_7);
  assign sm_is_10    = (startup_mode_q == `OMARB_SM_10);
  assign sm_is_0_1   = (startup_mode_q == `OMARB_SM_0) |
                       (startup_mode_q == `OMARB_SM_1);
  // Option named as command source but not fitted: NET falls back to PU
  assign net_mode    = (net_command_source_q | s_option) ?
                       `OMARB_MODE_NET : `OMARB_MODE_PU;
  // An unassigned switch counts as neither on nor off
  assign pu_ext_on   = asg_pu_ext & s_pu_ext;
  assign pu_ext_off  = asg_pu_ext & ~s_pu_ext;

  // ****************************************************************
  // Priority chain
  // ****************************************************************
  // Forced marks settings that override the run state of the motor
  reg  [1:0]  target;
  reg         forced;
  reg         change_req;

  // Priority: setting, interlock, startup, NET/External, NET/PU, PU/External
  always @* begin
    target     = op_mode_q;
    forced     = 1'b0;
    change_req = 1'b0;
    if (mode_select_q == `OMARB_MS_1) begin
      target = `OMARB_MODE_PU;
      forced = 1'b1;
    end else if ((mode_select_q == `OMARB_MS_3) || (mode_select_q == `OMARB_MS_4)) begin
      target = `OMARB_MODE_COMB;
      forced = 1'b1;
    end else if (ms_is_7 && !s_ilock) begin
      // Forced even with a start command present
      target = `OMARB_MODE_EXT;
      forced = 1'b1;
    end else if (sm_is_10 && ms_is_2) begin
      target = `OMARB_MODE_NET;
      forced = 1'b1;
    end else if (sm_is_10 && (ms_is_0 || ms_is_6) && asg_net_pu) begin
      change_req = 1'b1;
      if (s_net_pu) begin
        target = (asg_net_ext && s_net_ext) ? net_mode : `OMARB_MODE_PU;
      end else begin
        target = pu_ext_off ? `OMARB_MODE_PU : net_mode;
      end
    end else if (sm_is_10 && ms_is_7) begin
      if (asg_pu_ext) begin
        change_req = 1'b1;
        target = s_pu_ext ? `OMARB_MODE_EXT : `OMARB_MODE_PU;
      end
    end else if (sm_is_0_1 && asg_net_ext &&
                 (ms_is_0 || ms_is_2 || ms_is_6 || ms_is_7)) begin
      change_req = 1'b1;
      if (s_net_ext) begin
        target = net_mode;
      end else if (ms_is_2) begin
        target = `OMARB_MODE_EXT;
      end else if (asg_net_pu) begin
        target = s_net_pu ? `OMARB_MODE_PU : net_mode;
      end else begin
        target = pu_ext_off ? `OMARB_MODE_PU : `OMARB_MODE_EXT;
      end
    end else if (ms_is_2) begin
      target = `OMARB_MODE_EXT;
      forced = 1'b1;
    end else if ((ms_is_0 || ms_is_6 || ms_is_7) && asg_pu_ext) begin
      change_req = 1'b1;
      target = pu_ext_on ? `OMARB_MODE_EXT : `OMARB_MODE_PU;
    end
  end

  // ****************************************************************
  // Mode register
  // ****************************************************************
  wire        stopped;
  wire        may_change;
  wire        differs;
  wire        apply;
  reg  [1:0]  op_mode_d;

  // Stop means motor at rest and start off; setting 6 swaps while running
  assign stopped    = ~s_running & ~s_start;
  assign may_change = forced | stopped | ms_is_6;
  assign differs    = (target != op_mode_q);
  assign apply      = (forced | change_req) & differs & may_change;

  always @* begin
    op_mode_d = op_mode_q;
    if (apply) begin
      op_mode_d = target;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      op_mode_q <= `OMARB_MODE_EXT;
    end else begin
      op_mode_q <= op_mode_d;
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Output stop uses the mode being entered, so it never lags the mode
  always @(posedge clk) begin
    if (!rst_b) begin
      output_stop_q  <= 1'b0;
      mode_pending_q <= 1'b0;
    end else begin
      // A blocked request stays visible and is applied at the next stop
      mode_pending_q <= change_req & differs & ~may_change;
      // Setting 7 with the interlock input on stops output while External is active
      output_stop_q  <= ms_is_7 & s_ilock & (op_mode_d == `OMARB_MODE_EXT);
    end
  end

endmodule // omarb_top

// ### tb/omarb_checker.sv
// Port checker for the operation mode arbiter
`timescale 1ns/100ps
`include "omarb_regs.vh"
module omarb_checker (
  input wire        clk,
  input wire        rst_b,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  op_mode_q,
  input wire        output_stop_q,
  input wire        mode_pending_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_reset_ext_idle: assert property (disable iff (1'b0)
    !rst_b |=> op_mode_q == `OMARB_MODE_EXT && !output_stop_q && !mode_pending_q)
    else $error("mode not idle after reset");
  a_stop_only_ext: assert property (output_stop_q |-> op_mode_q == `OMARB_MODE_EXT)
    else $error("output stop outside External mode");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  cover property (output_stop_q);
  cover property (mode_pending_q);
  cover property (op_mode_q == `OMARB_MODE_NET);
endmodule // omarb_checker

// ### tb/omarb_pins.sv
// Model of the drive's input terminals
`timescale 1ns/100ps
module omarb_pins (
  input  wire       clk,
  input  wire [6:0] want,
  output reg  [6:0] pins_q
);
  // Terminals carry whatever functions the operator assigned
  initial pins_q = 7'h0;
  // Levels follow want on each rising edge, one clock after it is set
  always @(posedge clk) begin
    pins_q <= want;
  end
endmodule // omarb_pins

// ### tb/tb_omarb_top.sv
// Self-checking bench for the operation mode arbiter
`timescale 1ns/100ps
`include "omarb_regs.vh"
module tb_omarb_top;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [3:0]  awaddr = 4'h0, araddr = 4'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg  [31:0] wdata = 32'h0, rd, r;
  reg  [6:0]  want = 7'h0;
  reg  [1:0]  rs;
  wire [6:0]  p;
  wire [1:0]  bresp, rresp, mode;
  wire [31:0] rdata;
  wire        awready, wready, bvalid, arready, rvalid, stop, pend;
  integer     err_count = 0, cmp_count = 0, i;
  always #12.5 clk = ~clk;
  omarb_pins u_pins (.clk(clk), .want(want), .pins_q(p));
  omarb_top DUT (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pu_ext_switch(p[0]), .net_pu_switch(p[1]), .net_ext_switch(p[2]), .pu_interlock(p[3]),
    .motor_running(p[4]), .start_cmd(p[5]), .comm_option_fitted(p[6]), .op_mode_q(mode),
    .output_stop_q(stop), .mode_pending_q(pend));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task final_report;
    begin
      $display("checks %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task tmo(input integer n);
    if (n >= 40) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t bus hang", $time);
      final_report;
    end
  endtask
  // Master never assumes a latency: every wait is bounded by tmo
  task axi_write(input [3:0] a, input [31:0] d);
    reg ga, gw;
    integer n;
    begin
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      ga = 1'b0; gw = 1'b0; n = 0;
      do begin
        @(posedge clk); n = n + 1;
        if (!ga && awready) begin ga = 1'b1; awvalid <= 1'b0; end
        if (!gw && wready) begin gw = 1'b1; wvalid <= 1'b0; end
      end while (!(ga && gw) && n < 40);
      tmo(n);
      bready <= 1'b1; n = 0;
      do begin @(posedge clk); n = n + 1; end while (!bvalid && n < 40);
      tmo(n);
      rs = bresp; bready <= 1'b0;
    end
  endtask
  task axi_read(input [3:0] a);
    integer n;
    begin
      araddr <= a; arvalid <= 1'b1; n = 0;
      do begin @(posedge clk); n = n + 1; end while (!arready && n < 40);
      tmo(n);
      arvalid <= 1'b0; rready <= 1'b1; n = 0;
      do begin @(posedge clk); n = n + 1; end while (!rvalid && n < 40);
      tmo(n);
      rd = rdata; rs = rresp; rready <= 1'b0;
    end
  endtask
  function [1:0] exp_fixed(input c);
    exp_fixed = c ? `OMARB_MODE_COMB : `OMARB_MODE_PU;
  endfunction
  // Pins {option,start,running,interlock,net_ext,net_pu,pu_ext}
  task run_case(input [3:0] ms, sm, asg, input [6:0] pv, input [1:0] md, input pd, st);
    begin
      axi_write(`OMARB_ASSIGN_OFS, {28'h0, asg});
      axi_write(`OMARB_CTRL_OFS, {20'h0, sm, 4'h0, ms});
      want <= pv;
      repeat (6) @(posedge clk);
      check(mode, md);
      check(pend, pd);
      check(stop, st);
      axi_read(`OMARB_STATUS_OFS);
      check(rd[3:0], {pd, st, md});
      $display("case done ms %0d pins %h", ms, pv);
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i = $urandom(75);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axi_read(`OMARB_CTRL_OFS);
    check(rd, 32'h0);
    axi_read(4'hc);
    check(rs, `OMARB_RESP_DECERR);
    axi_write(4'hc, 32'h1);
    check(rs, `OMARB_RESP_DECERR);
    run_case(4'h0, 4'h0, 4'h1, 7'h00, 2'h1, 1'b0, 1'b0);
    run_case(4'h0, 4'h0, 4'h1, 7'h01, 2'h0, 1'b0, 1'b0);
    run_case(4'h0, 4'h0, 4'h1, 7'h10, 2'h0, 1'b1, 1'b0);
    run_case(4'h0, 4'h0, 4'h1, 7'h00, 2'h1, 1'b0, 1'b0);
    run_case(4'h6, 4'h0, 4'h1, 7'h31, 2'h0, 1'b0, 1'b0);
    run_case(4'h1, 4'h0, 4'h1, 7'h01, 2'h1, 1'b0, 1'b0);
    run_case(4'h3, 4'h0, 4'h1, 7'h00, 2'h3, 1'b0, 1'b0);
    run_case(4'h7, 4'h0, 4'h1, 7'h00, 2'h0, 1'b0, 1'b0);
    run_case(4'h7, 4'h0, 4'h1, 7'h09, 2'h0, 1'b0, 1'b1);
    run_case(4'h7, 4'h0, 4'h1, 7'h08, 2'h1, 1'b0, 1'b0);
    run_case(4'h2, 4'h0, 4'h4, 7'h44, 2'h2, 1'b0, 1'b0);
    run_case(4'h2, 4'h0, 4'h4, 7'h40, 2'h0, 1'b0, 1'b0);
    run_case(4'h0, 4'h0, 4'h5, 7'h44, 2'h2, 1'b0, 1'b0);
    run_case(4'h0, 4'h0, 4'h5, 7'h04, 2'h1, 1'b0, 1'b0);
    run_case(4'h2, 4'ha, 4'h0, 7'h40, 2'h2, 1'b0, 1'b0);
    run_case(4'h0, 4'ha, 4'h2, 7'h42, 2'h1, 1'b0, 1'b0);
    run_case(4'h0, 4'ha, 4'h2, 7'h40, 2'h2, 1'b0, 1'b0);
    run_case(4'h0, 4'ha, 4'h6, 7'h46, 2'h2, 1'b0, 1'b0);
    run_case(4'h7, 4'ha, 4'h3, 7'h49, 2'h0, 1'b0, 1'b1);
    run_case(4'h0, 4'h0, 4'h6, 7'h42, 2'h1, 1'b0, 1'b0);
    for (i = 0; i < 12; i = i + 1) begin
      r = $urandom;
      run_case(r[0] ? 4'h3 : 4'h1, 4'h0, {1'b0, r[3:1]}, r[10:4] & 7'h4f,
        exp_fixed(r[0]), 1'b0, 1'b0);
    end
    final_report;
  end
endmodule // tb_omarb_top
bind omarb_top omarb_checker u_chk (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .op_mode_q(op_mode_q),
  .output_stop_q(output_stop_q), .mode_pending_q(mode_pending_q));
